// ===== dv/ris_sequencer_chk.sv
`default_nettype none
module ris_sequencer_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic reset_n_i, // pin
  input wire logic [3:0] wb_adr_i, // addr
  input wire logic [31:0] wb_dat_i, // wdata
  input wire logic wb_we_i, // write
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic [31:0] wb_dat_o, // rdata
  input wire logic wb_ack_o, // ack
  input wire logic core_reset_o, // reset
  input wire logic [7:0] ddr_clear_o, // dir clear
  input wire logic timer_reset_o, // timer
  input wire logic stop_latch_o, // stop
  input wire logic wait_latch_o, // wait
  input wire logic busy_o, // busy
  input wire logic [2:0] stack_op_o // step
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_timing_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dir_clear_a:
    assert property (core_reset_o |-> ddr_clear_o == 8'hff)
    else $error("dir bits not cleared");
  timer_hold_a:
    assert property (timer_reset_o == core_reset_o)
    else $error("timer reset mismatch");
  latch_clear_a:
    assert property (core_reset_o && $past(core_reset_o)
      |-> !stop_latch_o && !wait_latch_o) else $error("latch kept");
  pin_reset_a:
    assert property (!reset_n_i [*6] |-> core_reset_o)
    else $error("pin low ignored");
  reset_abort_a:
    assert property (core_reset_o |=> busy_o && stack_op_o == 3'h0)
    else $error("sequence not abandoned");
  entry_len_a:
    assert property ($rose(busy_o) && !$past(core_reset_o)
      |-> (busy_o || core_reset_o) [*5])
    else $error("stacking cut short");
  trap_start_a:
    assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h6
      && wb_dat_i[1] |-> ##[1:3] busy_o) else $error("trap not taken");
  cover property ($rose(busy_o));
  cover property ($fell(core_reset_o));
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind ris_sequencer ris_sequencer_chk i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .reset_n_i(reset_n_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .core_reset_o(core_reset_o),
  .ddr_clear_o(ddr_clear_o),
  .timer_reset_o(timer_reset_o),
  .stop_latch_o(stop_latch_o),
  .wait_latch_o(wait_latch_o),
  .busy_o(busy_o),
  .stack_op_o(stack_op_o)
);
`default_nettype wire

// ===== dv/ris_src_model.sv
`default_nettype none
module ris_src_model (
  input wire logic clk_i, // clock
  output logic reset_n_o, // reset pin
  output logic irq_n_o, // shared irq pin
  output logic [2:0] flag_o // capture, compare, overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic src_a_n = 1'b1;
  logic src_b_n = 1'b1;
  logic rst_n_reg = 1'b1;
  logic [2:0] flag_reg = 3'h0;
  // Open-drain sources on a pulled-up pin
  assign irq_n_o = src_a_n & src_b_n;
  assign reset_n_o = rst_n_reg;
  assign flag_o = flag_reg;
  // Whole cycles only, never below the sensing window
  // Starts at once so the reset can land inside a running sequence
  task automatic pull_reset(input int n);
    rst_n_reg <= 1'b0;
    repeat (n) @(posedge clk_i);
    rst_n_reg <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, dat;
  logic rn, irqn, ack, crst, busy, stop, wt;
  logic [2:0] fl;
  int n_errors = 0;
  int check_count = 0;
  always #50 clk_i = ~clk_i;
  ris_src_model i_src (.clk_i(clk_i), .reset_n_o(rn), .irq_n_o(irqn),
    .flag_o(fl));
  ris_sequencer #(.POR_CYCLES(16), .WDOG_STAGES(8)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .reset_n_i(rn), .irq_n_i(irqn), .capture_flag_i(fl[2]),
    .compare_flag_i(fl[1]), .overflow_flag_i(fl[0]), .rom_data_i(8'h5a),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_we_i(we),
    .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(dat), .wb_ack_o(ack),
    .core_reset_o(crst), .ddr_clear_o(), .timer_reset_o(),
    .timer_load_o(), .stop_latch_o(stop), .wait_latch_o(wt), .busy_o(busy),
    .stack_op_o());
  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic [3:0] a, input logic w, logic [31:0] d);
    adr <= a;
    we <= w;
    wd <= d;
    stb <= 1'b1;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rd = dat;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Bounded wait, then service the watchdog so only t_wdog lets it expire
  task automatic settle();
    int t = 0;
    while ((crst | busy) !== 1'b0 && t < 400) begin
      @(posedge clk_i);
      t++;
    end
    wb(4'h0, 1'b1, 32'h0);
  endtask
  task automatic run(input logic [31:0] c, e);
    wb(4'h6, 1'b1, c);
    tick(2);
    chk({31'h0, busy}, 32'h1);
    settle();
    wb(4'h4, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_reset();
    tick(24);
    chk({31'h0, crst}, 32'h1);
    i_src.rst_n_reg <= 1'b1;
    settle();
    wb(4'h4, 1'b0, 32'h0);
    chk(rd, 32'h1ffe);
    wb(4'h1, 1'b0, 32'h0);
    chk(rd & 32'h1e0, 32'h100);
    wb(4'h5, 1'b0, 32'h0);
    chk(rd, 32'hff);
    wb(4'h3, 1'b0, 32'h0);
    chk(rd, 32'hfffc);
    wb(4'h0, 1'b0, 32'h0);
    chk(rd, 32'h5a);
    wb(4'hf, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_wdog();
    int t = 0;
    repeat (5) begin
      tick(100);
      wb(4'h0, 1'b1, 32'h0);
      chk({31'h0, crst}, 32'h0);
    end
    wb(4'h0, 1'b1, 32'h1);
    while (crst !== 1'b1 && t < 300) begin
      @(posedge clk_i);
      t++;
    end
    chk({31'h0, crst}, 32'h1);
    settle();
  endtask
  task automatic t_irq();
    wb(4'h1, 1'b1, 32'h1e0);
    i_src.flag_reg <= 3'h7;
    i_src.src_a_n <= 1'b0;
    i_src.src_b_n <= 1'b0;
    wb(4'h6, 1'b1, 32'h1);
    tick(3);
    chk({31'h0, busy}, 32'h0);
    wb(4'h1, 1'b1, 32'h0e0);
    tick(8);
    chk({31'h0, busy}, 32'h0);
    run(32'h1, 32'h1ffa);
    i_src.src_b_n <= 1'b1;
    wb(4'h1, 1'b0, 32'h0);
    chk(rd & 32'h100, 32'h100);
    wb(4'h2, 1'b0, 32'h0);
    chk(rd & 32'h80, 32'h0);
    wb(4'h1, 1'b1, 32'h0e0);
    run(32'h1, 32'h1ffa);
    i_src.src_a_n <= 1'b1;
    wb(4'h1, 1'b1, 32'h0e0);
    run(32'h1, 32'h1ff8);
    i_src.flag_reg <= 3'h0;
    run(32'h4, 32'h1ffa);
    wb(4'h1, 1'b0, 32'h0);
    chk(rd & 32'h100, 32'h0);
  endtask
  task automatic t_swi();
    wb(4'h1, 1'b1, 32'h100);
    run(32'h2, 32'h1ffc);
    wb(4'h6, 1'b1, 32'h18);
    // Pin goes low with the trap so reset cuts the stacking short
    fork
      i_src.pull_reset(8);
      begin
        wb(4'h6, 1'b1, 32'h1a);
        chk({30'h0, stop, wt}, 32'h3);
      end
    join
    chk({31'h0, crst}, 32'h1);
    chk({30'h0, stop, wt}, 32'h0);
    settle();
  endtask
  initial begin
    i_src.rst_n_reg <= 1'b0;
    tick(12);
    rst_i <= 1'b0;
    t_reset();
    t_wdog();
    t_irq();
    t_swi();
    give_verdict();
  end
  initial begin
    tick(20000);
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== logic/ris_pkg.sv
`default_nettype none
package ris_pkg;
  localparam logic [15:0] RIS_WDOG_ADDR = 16'h1ff0;
  localparam int RIS_WDOG_CLR_BIT = 0;
  localparam logic [7:0] RIS_SP_RESET = 8'hff;
  localparam logic [15:0] RIS_TIMER_RESET = 16'hfffc;
  localparam logic [15:0] RIS_VEC_RESET = 16'h1ffe;
  localparam logic [15:0] RIS_VEC_SWI = 16'h1ffc;
  localparam logic [15:0] RIS_VEC_EXT = 16'h1ffa;
  localparam logic [15:0] RIS_VEC_TIMER = 16'h1ff8;
  localparam int RIS_POR_CYCLES = 4064;
  localparam int RIS_WDOG_STAGES = 18;
  // Register map for software-visible control/status (word addressed)
  localparam logic [3:0] RIS_ADR_WDOG = 4'h0;
  localparam logic [3:0] RIS_ADR_CTRL = 4'h1;
  localparam logic [3:0] RIS_ADR_STAT = 4'h2;
  localparam logic [3:0] RIS_ADR_TIMER = 4'h3;
  localparam logic [3:0] RIS_ADR_PC = 4'h4;
  localparam logic [3:0] RIS_ADR_SP = 4'h5;
  localparam logic [3:0] RIS_ADR_CMD = 4'h6;
  typedef enum logic [1:0] {
    RIS_SRC_NONE, RIS_SRC_EXT, RIS_SRC_TIMER, RIS_SRC_SWI
  } ris_src_t;
endpackage
`default_nettype wire

// ===== logic/ris_sequencer.sv
// Design decision made here: the Wishbone interface to the registers.
`default_nettype none
// Behaviour
// - Reset abandons the current instruction immediately
// - Reset clears all port direction bits
// - Reset loads stack pointer with FF
// - Reset sets the interrupt mask
// - Reset clears timer divider, loads FFFC, clears bits
// - Reset clears stop and wait latches
// - After reset fetch vector at 1FFE/1FFF
// - Power-up holds reset 4064 cycles, pin extends
// - Reset pin low sensed enters reset
// - Reset pin is input only
// - Watchdog 18-stage counter expiry causes reset
// - Writing zero to bit 0 restarts watchdog
// - Watchdog address read returns ROM data
// - Interrupts sampled only at instruction completion
// - Timer request needs flag, enable, clear mask
// - Stack PROGRAM_COUNTER_LOW, PROGRAM_COUNTER_HIGH, X, A, CC; mask; vector
// - Return pulls CC, A, X, PROGRAM_COUNTER_HIGH, PROGRAM_COUNTER_LOW
// - External wins over timer interrupt
// - Software trap ignores mask, vector 1FFC
// - External interrupt vectors through 1FFA/1FFB
// - Latch clears at vector fetch; edge option
// - Level mode pends while pin held low
module ris_sequencer
  import ris_pkg::*;
#(
  parameter int POR_CYCLES = ris_pkg::RIS_POR_CYCLES,
  parameter int WDOG_STAGES = ris_pkg::RIS_WDOG_STAGES,
  parameter bit WDOG_ENABLE = 1'b1,
  parameter bit IRQ_LEVEL_MODE = 1'b1
) (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_i, // Power-on reset, sync high
  input wire logic reset_n_i, // External reset pin
  input wire logic irq_n_i, // External interrupt pin
  input wire logic capture_flag_i, // Timer capture flag
  input wire logic compare_flag_i, // Timer compare flag
  input wire logic overflow_flag_i, // Timer overflow flag
  input wire logic [7:0] rom_data_i, // ROM byte under watchdog addr
  input wire logic [3:0] wb_adr_i, // Wishbone word address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables
  input wire logic wb_we_i, // Wishbone write
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic core_reset_o, // Internal reset to core
  output logic [7:0] ddr_clear_o, // Direction bits forced low
  output logic timer_reset_o, // Timer divider/counter reset
  output logic [15:0] timer_load_o, // Timer reload value
  output logic stop_latch_o, // Stop latch
  output logic wait_latch_o, // Wait latch
  output logic busy_o, // Stacking, unstacking or vector fetch in progress
  output logic [2:0] stack_op_o // Last stack step index
);
  import ris_pkg::*;

  typedef enum {ST_RUN, ST_PUSH, ST_VEC, ST_PULL} ris_state_t;

  logic [1:0] rpin_sync_reg;
  logic [1:0] irq_sync_reg;
  logic [1:0] rpin_low_reg;
  logic irq_prev_reg;
  logic irq_latch_reg;
  logic [12:0] por_cnt_reg;
  logic por_done_reg;
  logic [WDOG_STAGES-1:0] wdog_reg;
  logic wdog_expire;
  logic sys_reset;
  logic [7:0] sp_reg;
  logic [15:0] pc_reg;
  logic [7:0] acc_reg;
  logic [7:0] idx_reg;
  logic [7:0] cc_reg;
  logic imask;
  logic [7:0] stack_mem [0:255];
  logic [2:0] step_reg;
  ris_state_t state_reg;
  ris_src_t src_reg;
  logic [15:0] vec_addr;
  logic capture_en_reg;
  logic compare_en_reg;
  logic overflow_en_reg;
  logic compare_output_bit_reg;
  logic output_level_bit_reg;
  logic stop_reg;
  logic wait_reg;
  logic insn_done_reg;
  logic trap_req_reg;
  logic rti_req_reg;
  logic ext_req;
  logic tmr_req;
  logic wb_hit;
  logic wr_cmd;
  logic wdog_clear;

  assign imask = cc_reg[3];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = wb_hit && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    rpin_sync_reg <= {rpin_sync_reg[0], reset_n_i};
    irq_sync_reg <= {irq_sync_reg[0], irq_n_i};
  end

  // A single low sample, delayed two cycles, enters reset; the 1.5 cycle minimum is not checked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpin_low_reg <= 2'b00;
    end else begin
      rpin_low_reg <= {rpin_low_reg[0], !rpin_sync_reg[1]};
    end
  end

  // Power-up delay; pin low at the end extends reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_cnt_reg <= '0;
      por_done_reg <= 1'b0;
    end else if (por_cnt_reg != 13'(POR_CYCLES - 1)) begin
      por_cnt_reg <= por_cnt_reg + 13'h0001;
    end else begin
      por_done_reg <= 1'b1;
    end
  end

  assign wdog_clear = wr_cmd && (wb_adr_i == RIS_ADR_WDOG)
    && !wb_dat_i[RIS_WDOG_CLR_BIT];
  assign wdog_expire = WDOG_ENABLE && (&wdog_reg);

  always_ff @(posedge clk_i) begin
    if (sys_reset || wdog_clear) begin
      wdog_reg <= '0;
    end else if (WDOG_ENABLE && !stop_reg) begin
      wdog_reg <= wdog_reg + 1'b1;
    end
  end

  // Pin is never driven: no output exists for it
  assign sys_reset = rst_i || !por_done_reg || rpin_low_reg[1]
    || wdog_expire;

  // External request latch: edge sets it; in level mode a low pin raises ext_req directly, not the latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_prev_reg <= 1'b1;
    end else begin
      irq_prev_reg <= irq_sync_reg[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_reset) begin
      irq_latch_reg <= 1'b0;
    end else if (irq_prev_reg && !irq_sync_reg[1]) begin
      irq_latch_reg <= 1'b1; // Set wins over clear
    end else if (state_reg == ST_VEC && src_reg == RIS_SRC_EXT) begin
      irq_latch_reg <= 1'b0;
    end
  end

  assign ext_req = !imask && (irq_latch_reg
    || (IRQ_LEVEL_MODE && !irq_sync_reg[1]));
  assign tmr_req = !imask && ((capture_flag_i && capture_en_reg)
    || (compare_flag_i && compare_en_reg)
    || (overflow_flag_i && overflow_en_reg));

  always_comb begin
    unique case (src_reg)
      RIS_SRC_EXT: vec_addr = RIS_VEC_EXT;
      RIS_SRC_TIMER: vec_addr = RIS_VEC_TIMER;
      RIS_SRC_SWI: vec_addr = RIS_VEC_SWI;
      RIS_SRC_NONE: vec_addr = RIS_VEC_RESET;
    endcase
  end

  // Command strobes from software stand in for core decode
  always_ff @(posedge clk_i) begin
    if (sys_reset) begin
      insn_done_reg <= 1'b0;
      trap_req_reg <= 1'b0;
      rti_req_reg <= 1'b0;
    end else begin
      insn_done_reg <= wr_cmd && (wb_adr_i == RIS_ADR_CMD) && wb_dat_i[0];
      trap_req_reg <= wr_cmd && (wb_adr_i == RIS_ADR_CMD) && wb_dat_i[1];
      rti_req_reg <= wr_cmd && (wb_adr_i == RIS_ADR_CMD) && wb_dat_i[2];
    end
  end

  // Sequencer: reset aborts anything in flight
  always_ff @(posedge clk_i) begin
    if (sys_reset) begin
      state_reg <= ST_VEC;
      src_reg <= RIS_SRC_NONE;
      step_reg <= 3'h0;
      sp_reg <= RIS_SP_RESET;
      cc_reg <= 8'h08;
      pc_reg <= 16'h0000;
      acc_reg <= 8'h00;
      idx_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (trap_req_reg) begin
            src_reg <= RIS_SRC_SWI;
            state_reg <= ST_PUSH;
            step_reg <= 3'h0;
          end else if (rti_req_reg) begin
            state_reg <= ST_PULL;
            step_reg <= 3'h0;
          end else if (insn_done_reg && ext_req) begin
            src_reg <= RIS_SRC_EXT;
            state_reg <= ST_PUSH;
            step_reg <= 3'h0;
          end else if (insn_done_reg && tmr_req) begin
            src_reg <= RIS_SRC_TIMER;
            state_reg <= ST_PUSH;
            step_reg <= 3'h0;
          end
        end
        ST_PUSH: begin
          unique case (step_reg)
            3'h0: stack_mem[sp_reg] <= pc_reg[7:0];
            3'h1: stack_mem[sp_reg] <= pc_reg[15:8];
            3'h2: stack_mem[sp_reg] <= idx_reg;
            3'h3: stack_mem[sp_reg] <= acc_reg;
            default: stack_mem[sp_reg] <= cc_reg;
          endcase
          sp_reg <= sp_reg - 8'h01;
          step_reg <= step_reg + 3'h1;
          if (step_reg == 3'h4) begin
            cc_reg[3] <= 1'b1;
            state_reg <= ST_VEC;
          end
        end
        ST_VEC: begin
          pc_reg <= vec_addr; // Vector address handed to fetch
          state_reg <= ST_RUN;
        end
        ST_PULL: begin
          unique case (step_reg)
            3'h0: cc_reg <= stack_mem[sp_reg + 8'h01];
            3'h1: acc_reg <= stack_mem[sp_reg + 8'h01];
            3'h2: idx_reg <= stack_mem[sp_reg + 8'h01];
            3'h3: pc_reg[15:8] <= stack_mem[sp_reg + 8'h01];
            default: pc_reg[7:0] <= stack_mem[sp_reg + 8'h01];
          endcase
          sp_reg <= sp_reg + 8'h01;
          step_reg <= step_reg + 3'h1;
          if (step_reg == 3'h4) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
      if (state_reg == ST_RUN && wr_cmd && wb_adr_i == RIS_ADR_CTRL) begin
        cc_reg[3] <= wb_dat_i[8];
      end
    end
  end

  // Timer side effects of reset; enables steerable by software
  always_ff @(posedge clk_i) begin
    if (sys_reset) begin
      capture_en_reg <= 1'b0;
      compare_en_reg <= 1'b0;
      overflow_en_reg <= 1'b0;
      compare_output_bit_reg <= 1'b0;
      output_level_bit_reg <= 1'b0;
    end else if (wr_cmd && wb_adr_i == RIS_ADR_CTRL) begin
      capture_en_reg <= wb_dat_i[7];
      compare_en_reg <= wb_dat_i[6];
      overflow_en_reg <= wb_dat_i[5];
      output_level_bit_reg <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_reset) begin
      stop_reg <= 1'b0;
      wait_reg <= 1'b0;
    end else if (wr_cmd && wb_adr_i == RIS_ADR_CMD) begin
      stop_reg <= wb_dat_i[3];
      wait_reg <= wb_dat_i[4];
    end
  end

  assign core_reset_o = sys_reset;
  assign ddr_clear_o = {8{sys_reset}};
  assign timer_reset_o = sys_reset;
  assign timer_load_o = RIS_TIMER_RESET;
  assign stop_latch_o = stop_reg;
  assign wait_latch_o = wait_reg;
  assign busy_o = (state_reg != ST_RUN);
  assign stack_op_o = step_reg;

  // Wishbone slave: one wait-state ack, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          RIS_ADR_WDOG: wb_dat_o <= {24'h0, rom_data_i};
          RIS_ADR_CTRL: wb_dat_o <= {23'h0, imask, capture_en_reg,
            compare_en_reg, overflow_en_reg, 3'h0,
            compare_output_bit_reg, output_level_bit_reg};
          RIS_ADR_STAT: wb_dat_o <= {24'h0, irq_latch_reg, ext_req,
            tmr_req, stop_reg, wait_reg, src_reg, busy_o};
          RIS_ADR_TIMER: wb_dat_o <= {16'h0, timer_load_o};
          RIS_ADR_PC: wb_dat_o <= {16'h0, pc_reg};
          RIS_ADR_SP: wb_dat_o <= {24'h0, sp_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
